// ===== bench/flac_rst_model.sv
// Reset controller model that answers the flash error reset request.
`timescale 1ns/1ps
module flac_rst_model (
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    input  wire logic       req_in,
    input  wire logic [3:0] delay_in,
    output logic            dev_reset_out
);
    // ------------------------------------------------------------------
    // Request to reset pulse
    // ------------------------------------------------------------------
    logic [3:0] wait_q;

    // The pulse comes a variable number of cycles after the request, so
    // the bench sees both prompt and slow controllers.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wait_q        <= 4'h0;
            dev_reset_out <= 1'b0;
        end else if (dev_reset_out) begin
            wait_q        <= 4'h0;
            dev_reset_out <= 1'b0;          // One-cycle device reset.
        end else if (req_in) begin
            if (wait_q >= delay_in) begin
                dev_reset_out <= 1'b1;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            wait_q <= 4'h0;
        end
    end
endmodule : flac_rst_model

// ===== bench/tb.sv
// Self-checking bench for the flash lock permission checker.
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------------
    // Signals and reference state
    // ------------------------------------------------------------------
    localparam logic [4:0] LP = flac_pkg::LOCK_PAGE_DEF;
    logic       clk, rstn, req_valid, req_src, req_lb, ven, vsrc, dev_reset;
    logic [1:0] req_op;
    logic [4:0] req_page, exec_page;
    logic [7:0] req_wdata;
    logic [3:0] rst_delay;
    logic       grant, ignore, violation, full_erase, rst_req, err_flag;
    logic [7:0] lock_byte, active_lock;
    logic       lock_written;
    logic [7:0] m_sto, m_act, c_wd;
    logic       m_wr, m_rq, m_flag, c_v, c_lb, c_dr;
    logic [1:0] c_op;
    logic [2:0] c_exp;
    int         err_total, compares, seed, i;
    logic [31:0] r;
    logic [4:0] pg;
    logic [1:0] op;

    flac_checker dut (.clock_in(clk), .rstn_in(rstn), .req_valid_in(req_valid),
        .req_src_in(req_src), .req_op_in(req_op), .req_page_in(req_page),
        .req_lock_byte_in(req_lb), .req_wdata_in(req_wdata),
        .exec_page_in(exec_page), .vdd_mon_en_in(ven), .vdd_mon_src_in(vsrc),
        .dev_reset_in(dev_reset), .grant_out(grant), .ignore_out(ignore),
        .violation_out(violation), .full_erase_out(full_erase),
        .flash_error_reset_out(rst_req), .flash_error_flag_out(err_flag),
        .lock_byte_out(lock_byte), .active_lock_out(active_lock),
        .lock_written_out(lock_written));

    flac_rst_model partner (.clock_in(clk), .rstn_in(rstn), .req_in(rst_req),
        .delay_in(rst_delay), .dev_reset_out(dev_reset));

    // ------------------------------------------------------------------
    // Expectation functions
    // ------------------------------------------------------------------
    // A cleared bit locks its page; the lock page follows any lock.
    function automatic logic lkd(input logic [4:0] p);
        if (p == LP) lkd = ~&m_act;
        else if (p < 5'h08) lkd = ~m_act[p[2:0]];
        else lkd = 1'b0;
    endfunction : lkd

    // Returns grant, ignore, violation as three bits.
    function automatic logic [2:0] exp_fn(input logic s, input logic [1:0] o,
        input logic [4:0] p, input logic lb, input logic [4:0] ex,
        input logic ve, input logic vs);
        logic ok;
        if (p > LP) ok = 1'b0;
        else if (o == flac_pkg::OP_FULL_ERASE) ok = s;
        else if (lb && o == flac_pkg::OP_WRITE) ok = !m_wr;
        else if (p == LP && o == flac_pkg::OP_ERASE) ok = s && &m_act;
        else ok = !lkd(p) || (!s && lkd(ex));
        if (!s && o != flac_pkg::OP_READ && !(ve && vs)) ok = 1'b0;
        exp_fn = ok ? 3'b100 : (s ? 3'b010 : 3'b001);
    endfunction : exp_fn

    // ------------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------------
    task automatic chk1(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // One clock of traffic: apply last edge, drive, check when settled
    // ------------------------------------------------------------------
    task automatic cycle(input logic v, input logic s, input logic [1:0] o,
        input logic [4:0] p, input logic lb, input logic [7:0] wd,
        input logic [4:0] ex, input logic ve, input logic vs);
        logic [2:0] e;
        @(posedge clk);
        if (c_v && c_exp[2] && c_lb && c_op == flac_pkg::OP_WRITE) begin
            m_sto = c_wd;
            m_wr  = 1'b1;
        end
        if (c_v && c_exp[2] && c_op == flac_pkg::OP_FULL_ERASE) begin
            m_sto = 8'hFF;
            m_act = 8'hFF;
            m_wr  = 1'b0;
        end
        if (c_dr) begin
            m_act  = m_sto;
            m_flag = m_rq;
        end
        if (c_v && c_exp[0]) m_rq = 1'b1;
        else if (c_dr) m_rq = 1'b0;
        req_valid <= v; req_src <= s; req_op <= o; req_page <= p;
        req_lb <= lb; req_wdata <= wd; exec_page <= ex; ven <= ve; vsrc <= vs;
        rst_delay <= 4'($random(seed));
        @(negedge clk);
        e = v ? exp_fn(s, o, p, lb, ex, ve, vs) : 3'b000;
        c_v = v; c_op = o; c_lb = lb; c_wd = wd; c_exp = e; c_dr = dev_reset;
        chk1("grant", e[2], grant);
        chk1("ignore", e[1], ignore);
        chk1("violation", e[0], violation);
        chk1("full_erase", e[2] && o == 2'h3, full_erase);
        chk1("reset_req", m_rq, rst_req);
        chk1("error_flag", m_flag, err_flag);
        chk8("stored", m_sto, lock_byte);
        chk8("active", m_act, active_lock);
        chk1("written", m_wr, lock_written);
    endtask : cycle

    // A request, then idle cycles until any device reset it caused is over.
    task automatic step(input logic s, input logic [1:0] o,
        input logic [4:0] p, input logic lb, input logic [7:0] wd,
        input logic [4:0] ex, input logic ve, input logic vs);
        int n;
        cycle(1'b1, s, o, p, lb, wd, ex, ve, vs);
        n = 0;
        while ((m_rq || c_exp[0] || c_dr) && n < 40) begin
            cycle(1'b0, 1'b0, 2'h0, 5'h00, 1'b0, 8'h00, 5'h00, 1'b1, 1'b1);
            n++;
        end
        if (n == 40) begin
            err_total++;
            $display("ERROR device_reset expected pulse seen none");
            end_sim();
        end
    endtask : step

    // ------------------------------------------------------------------
    // Clock, reset and test sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        rstn = 1'b0; req_valid = 1'b0; req_src = 1'b0; req_op = 2'h0;
        req_page = 5'h00; req_lb = 1'b0; req_wdata = 8'h00; exec_page = 5'h00;
        ven = 1'b1; vsrc = 1'b1; rst_delay = 4'h0; seed = 30048;
        err_total = 0; compares = 0; m_sto = 8'hFF; m_act = 8'hFF;
        m_wr = 1'b0; m_rq = 1'b0; m_flag = 1'b0; c_v = 1'b0; c_lb = 1'b0;
        c_dr = 1'b0; c_op = 2'h0; c_wd = 8'h00; c_exp = 3'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        // Corner cases: lock, delayed activation, refusals, full erase.
        step(1'b1, 2'h0, 5'h00, 1'b0, 8'h00, 5'h03, 1'b1, 1'b1);
        step(1'b0, 2'h1, LP, 1'b1, 8'hFE, 5'h03, 1'b1, 1'b1);
        step(1'b1, 2'h0, 5'h00, 1'b0, 8'h00, 5'h03, 1'b1, 1'b1);
        step(1'b1, 2'h1, LP, 1'b1, 8'hFC, 5'h03, 1'b1, 1'b1);
        step(1'b0, 2'h0, 5'h1F, 1'b0, 8'h00, 5'h00, 1'b1, 1'b1);
        step(1'b1, 2'h0, 5'h00, 1'b0, 8'h00, 5'h03, 1'b1, 1'b1);
        step(1'b0, 2'h1, 5'h00, 1'b0, 8'h00, 5'h03, 1'b1, 1'b1);
        step(1'b0, 2'h1, 5'h00, 1'b0, 8'h00, 5'h00, 1'b1, 1'b1);
        step(1'b1, 2'h0, LP, 1'b1, 8'h00, 5'h03, 1'b1, 1'b1);
        step(1'b0, 2'h0, LP, 1'b1, 8'h00, LP, 1'b1, 1'b1);
        step(1'b1, 2'h2, LP, 1'b0, 8'h00, 5'h03, 1'b1, 1'b1);
        step(1'b0, 2'h1, 5'h00, 1'b0, 8'h00, 5'h00, 1'b0, 1'b1);
        step(1'b1, 2'h3, 5'h00, 1'b0, 8'h00, 5'h03, 1'b1, 1'b1);
        step(1'b1, 2'h2, LP, 1'b0, 8'h00, 5'h03, 1'b1, 1'b1);
        step(1'b0, 2'h2, LP, 1'b0, 8'h00, 5'h00, 1'b1, 1'b1);
        step(1'b0, 2'h1, LP, 1'b1, 8'h01, 5'h03, 1'b1, 1'b1);
        step(1'b0, 2'h1, LP, 1'b1, 8'hFF, 5'h00, 1'b1, 1'b1);
        $display("test directed done");
        // Random traffic; the lock page is favoured to reach its corners.
        for (i = 0; i < 400; i++) begin
            r  = $random(seed);
            pg = r[5] ? LP : r[4:0];
            op = r[7:6];
            if (op == 2'h3) pg = 5'h00;
            step(r[9], op, pg, r[8] && pg == LP && op < 2'h2, r[17:10],
                 r[22:18], r[23] | r[24], r[25] | r[26]);
        end
        $display("test random done");
        end_sim();
    end
endmodule : tb

// ===== logic/flac_checker.sv
// Flash page lock permission checker for firmware and debug requests.
`timescale 1ns/1ps
module flac_checker #(
    parameter logic [4:0] LOCK_PAGE = flac_pkg::LOCK_PAGE_DEF
) (
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    input  wire logic       req_valid_in,
    input  wire logic       req_src_in,
    input  wire logic [1:0] req_op_in,
    input  wire logic [4:0] req_page_in,
    input  wire logic       req_lock_byte_in,
    input  wire logic [7:0] req_wdata_in,
    input  wire logic [4:0] exec_page_in,
    input  wire logic       vdd_mon_en_in,
    input  wire logic       vdd_mon_src_in,
    input  wire logic       dev_reset_in,
    output logic            grant_out,
    output logic            ignore_out,
    output logic            violation_out,
    output logic            full_erase_out,
    output logic            flash_error_reset_out,
    output logic            flash_error_flag_out,
    output logic      [7:0] lock_byte_out,
    output logic      [7:0] active_lock_out,
    output logic            lock_written_out
);

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    logic is_fw;
    logic is_dbg;
    logic is_full;
    logic is_modify;
    logic is_reserved;
    logic is_lock_page;
    logic any_locked;
    logic tgt_locked;
    logic exec_locked;
    logic vdd_ok;
    logic ok;
    logic lock_wr;

    // Classify the request and the executing page.
    assign is_fw        = (req_src_in == flac_pkg::SRC_FIRMWARE);
    assign is_dbg       = (req_src_in == flac_pkg::SRC_DEBUG);
    assign is_full      = (req_op_in == flac_pkg::OP_FULL_ERASE);
    assign is_modify    = (req_op_in == flac_pkg::OP_WRITE)
                        || (req_op_in == flac_pkg::OP_ERASE);
    assign is_reserved  = (req_page_in > LOCK_PAGE);
    assign is_lock_page = (req_page_in == LOCK_PAGE);
    assign any_locked   = ~&active_lock_out;
    assign tgt_locked   = flac_pkg::page_locked(active_lock_out,
                                                req_page_in, LOCK_PAGE);
    assign exec_locked  = flac_pkg::page_locked(active_lock_out,
                                                exec_page_in, LOCK_PAGE);
    assign vdd_ok       = vdd_mon_en_in && vdd_mon_src_in;

    // ------------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------------
    // Pure combinational verdict so the flash sees it in the request
    // cycle; the cost is a longer path from the lock copy to the array.
    always_comb begin
        ok = 1'b0;
        if (is_full) begin
            ok = is_dbg;
        end else if (is_reserved) begin
            ok = 1'b0;
        end else if (is_lock_page && req_op_in == flac_pkg::OP_ERASE) begin
            // Firmware never erases it; debug only while nothing locks.
            ok = is_dbg && !any_locked;
        end else if (is_lock_page && req_lock_byte_in
                     && req_op_in == flac_pkg::OP_WRITE
                     && lock_written_out) begin
            // Any later change would lock or unlock pages.
            ok = 1'b0;
        end else if (is_lock_page) begin
            ok = !any_locked || (is_fw && exec_locked);
        end else if (!tgt_locked) begin
            ok = 1'b1;
        end else begin
            ok = is_fw && exec_locked;
        end
        // Firmware may only modify flash under the supply monitor reset.
        if (is_fw && is_modify && !vdd_ok) begin
            ok = 1'b0;
        end
    end

    // Split the refusal by requester.
    assign grant_out      = req_valid_in && ok;
    assign ignore_out     = req_valid_in && is_dbg && !ok;
    assign violation_out  = req_valid_in && is_fw && !ok;
    assign full_erase_out = grant_out && is_full;
    assign lock_wr        = grant_out && is_lock_page && req_lock_byte_in
                          && (req_op_in == flac_pkg::OP_WRITE);

    // ------------------------------------------------------------------
    // State holders
    // ------------------------------------------------------------------
    flac_lock_store u_store (
        .clock_in      (clock_in),
        .rstn_in       (rstn_in),
        .dev_reset_in  (dev_reset_in),
        .wr_en_in      (lock_wr),
        .wr_data_in    (req_wdata_in),
        .full_erase_in (full_erase_out),
        .stored_out    (lock_byte_out),
        .active_out    (active_lock_out),
        .written_out   (lock_written_out)
    );

    flac_err_flag u_flag (
        .clock_in      (clock_in),
        .rstn_in       (rstn_in),
        .violation_in  (violation_out),
        .dev_reset_in  (dev_reset_in),
        .reset_req_out (flash_error_reset_out),
        .flag_out      (flash_error_flag_out)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);

    // Debug refusals never become a reset request.
    a_dbg_no_reset: assert property (
        req_valid_in && is_dbg |=> !$rose(flash_error_reset_out))
        else $error("debug request raised a flash error reset");

    // Reserved pages are never granted to any request other than a full erase.
    a_reserved_deny: assert property (
        req_valid_in && !is_full && req_page_in > LOCK_PAGE
        |-> !grant_out && (ignore_out || violation_out))
        else $error("reserved area access was not refused");

    // A device reset taken while the request stands sets the flag.
    a_fer_flag: assert property (
        dev_reset_in && flash_error_reset_out
        |=> flash_error_flag_out)
        else $error("error flag not set after flash error reset");

    a_fer_request: assert property (
        violation_out |=> flash_error_reset_out)
        else $error("violation did not request a reset");

    // A lock byte write leaves the checks untouched until reset.
    a_lock_delay: assert property (
        lock_wr && !dev_reset_in
        |=> active_lock_out == $past(active_lock_out)
            && lock_byte_out == $past(req_wdata_in))
        else $error("lock byte write took effect before reset");

    // Full erase leaves every page unlocked.
    a_full_erase: assert property (
        req_valid_in && is_dbg && is_full
        |=> lock_byte_out == flac_pkg::LOCK_ERASED && !any_locked
            && !lock_written_out)
        else $error("full erase did not unlock all pages");

    // Once written, the lock byte refuses writes.
    a_lock_frozen: assert property (
        lock_written_out && req_valid_in && req_lock_byte_in
        && is_lock_page && req_op_in == flac_pkg::OP_WRITE |-> !grant_out)
        else $error("lock byte changed after first write");

    // Firmware erase of the lock page always resets.
    a_fw_lock_erase: assert property (
        req_valid_in && is_fw && is_lock_page
        && req_op_in == flac_pkg::OP_ERASE |-> violation_out)
        else $error("firmware erased the lock page");

    // Firmware modify without the supply monitor reset is refused.
    a_vdd_guard: assert property (
        req_valid_in && is_fw && is_modify && !vdd_ok |-> violation_out)
        else $error("firmware modified flash without monitor");

    // Debug to a locked ordinary page is ignored.
    a_locked_dbg: assert property (
        req_valid_in && is_dbg && !is_full && !is_lock_page
        && !is_reserved && tgt_locked |-> ignore_out)
        else $error("debug reached a locked page");

    // Unlocked ordinary pages are always read.
    a_unlocked_read: assert property (
        req_valid_in && req_op_in == flac_pkg::OP_READ && !is_lock_page
        && !is_reserved && !tgt_locked |-> grant_out)
        else $error("read of unlocked page refused");

    // The request stands until the device reset that answers it.
    a_fer_hold: assert property (
        flash_error_reset_out && !dev_reset_in |=> flash_error_reset_out)
        else $error("reset request dropped before device reset");

    // The device reset retires the request unless a new violation lands.
    a_fer_clear: assert property (
        flash_error_reset_out && dev_reset_in && !violation_out
        |=> !flash_error_reset_out)
        else $error("reset request outlived the device reset");

    // A reset with no pending request leaves the flag clear.
    a_flag_clean: assert property (
        dev_reset_in && !flash_error_reset_out |=> !flash_error_flag_out)
        else $error("error flag set by an unrelated reset");

    // With nothing locked the lock page reads for everyone.
    a_lockpg_open: assert property (
        req_valid_in && is_lock_page && !any_locked
        && req_op_in == flac_pkg::OP_READ |-> grant_out)
        else $error("open lock page read refused");

    // Once anything locks, the debug port loses the lock page.
    a_lockpg_dbg: assert property (
        req_valid_in && is_dbg && is_lock_page && !is_full && any_locked
        |-> ignore_out)
        else $error("debug reached the locked lock page");

    // Firmware reads the locked lock page only from a locked page.
    a_lockpg_fw: assert property (
        req_valid_in && is_fw && is_lock_page && any_locked
        && req_op_in == flac_pkg::OP_READ
        |-> grant_out == exec_locked && violation_out == !exec_locked)
        else $error("locked lock page read verdict wrong");

    // Under any lock only the full erase can clear the lock page.
    a_lockpg_erase: assert property (
        req_valid_in && is_lock_page && any_locked
        && req_op_in == flac_pkg::OP_ERASE |-> !grant_out)
        else $error("lock page erased while pages are locked");

    // A written lock byte cannot be rewritten by firmware at all.
    a_relock_fw: assert property (
        req_valid_in && is_fw && lock_written_out && is_lock_page
        && req_lock_byte_in && req_op_in == flac_pkg::OP_WRITE
        |-> violation_out)
        else $error("firmware changed the written lock byte");

    // A cleared bit shuts its page to the debug port; read straight
    // from the lock copy so a broken helper function still shows.
    a_bit_locked: assert property (
        req_valid_in && is_dbg && !is_full && req_page_in < 5'h08
        && !active_lock_out[req_page_in[2:0]] |-> ignore_out)
        else $error("debug reached a page with a cleared bit");

    // A set bit leaves its page readable by the debug port.
    a_bit_open: assert property (
        req_valid_in && is_dbg && req_op_in == flac_pkg::OP_READ
        && req_page_in < 5'h08 && active_lock_out[req_page_in[2:0]]
        |-> grant_out)
        else $error("debug refused a page with a set bit");

    // Every request gets exactly one verdict in its own cycle.
    a_one_verdict: assert property (
        req_valid_in |-> $onehot({grant_out, ignore_out, violation_out}))
        else $error("request did not get exactly one verdict");

    // No request, no verdict and no erase strobe.
    a_idle_quiet: assert property (
        !req_valid_in |-> !grant_out && !ignore_out && !violation_out
        && !full_erase_out)
        else $error("verdict raised with no request");

    // Firmware never starts a full erase.
    a_fw_full: assert property (
        req_valid_in && is_fw && is_full
        |-> violation_out && !full_erase_out)
        else $error("firmware full erase was not refused");

    // Refused debug requests leave the lock byte as it was.
    a_dbg_no_effect: assert property (
        ignore_out |=> lock_byte_out == $past(lock_byte_out)
            && lock_written_out == $past(lock_written_out))
        else $error("ignored debug request changed the lock byte");

    // Once written, only a full erase moves the stored byte.
    a_store_frozen: assert property (
        lock_written_out && !full_erase_out
        |=> lock_byte_out == $past(lock_byte_out))
        else $error("written lock byte changed without full erase");

    // The lock copy moves only at a device reset or a full erase.
    a_active_hold: assert property (
        !dev_reset_in && !full_erase_out
        |=> active_lock_out == $past(active_lock_out))
        else $error("lock copy changed outside a device reset");

    // A device reset hands the stored byte to the checks.
    a_active_load: assert property (
        dev_reset_in && !full_erase_out
        |=> active_lock_out == $past(lock_byte_out))
        else $error("device reset did not latch the lock byte");

    c_fer_cycle: cover property (
        violation_out ##[1:4] dev_reset_in ##1 flash_error_flag_out);
    c_lock_then_reset: cover property (
        lock_wr ##[1:8] dev_reset_in ##1 any_locked);
    c_full_erase: cover property (any_locked ##[1:8] full_erase_out);
    c_locked_fw_ok: cover property (
        grant_out && is_fw && tgt_locked && exec_locked);

endmodule : flac_checker

// ===== logic/flac_err_flag.sv
// Flash error reset request and the error flag seen after that reset.
`timescale 1ns/1ps
module flac_err_flag (
    input  wire logic clock_in,
    input  wire logic rstn_in,
    input  wire logic violation_in,
    input  wire logic dev_reset_in,
    output logic      reset_req_out,
    output logic      flag_out
);

    // A violation in the reset cycle itself is kept: set wins over clear.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reset_req_out <= 1'b0;
        end else if (violation_in) begin
            reset_req_out <= 1'b1;
        end else if (dev_reset_in) begin
            reset_req_out <= 1'b0;
        end
    end

    // Every device reset reloads the flag with its own cause.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_out <= 1'b0;
        end else if (dev_reset_in) begin
            flag_out <= reset_req_out;
        end
    end

endmodule : flac_err_flag

// ===== logic/flac_lock_store.sv
// Non-volatile lock byte image and the lock state latched at reset.
`timescale 1ns/1ps
module flac_lock_store (
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    input  wire logic       dev_reset_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       full_erase_in,
    output logic      [7:0] stored_out,
    output logic      [7:0] active_out,
    output logic            written_out
);

    logic boot_q;

    // Stored byte and its written mark; a full erase returns both.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stored_out  <= flac_pkg::LOCK_ERASED;
            written_out <= 1'b0;
        end else if (full_erase_in) begin
            stored_out  <= flac_pkg::LOCK_ERASED;
            written_out <= 1'b0;
        end else if (wr_en_in) begin
            stored_out  <= wr_data_in;
            written_out <= 1'b1;
        end
    end

    // The checks use a copy taken only at a device reset or on the first clock after rstn_in, and set to erased by a full erase,
    // so firmware cannot change its own rights mid-run.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            active_out <= flac_pkg::LOCK_ERASED;
            boot_q     <= 1'b1;
        end else begin
            boot_q <= 1'b0;
            if (full_erase_in) begin
                active_out <= flac_pkg::LOCK_ERASED;
            end else if (boot_q || dev_reset_in) begin
                active_out <= stored_out;
            end
        end
    end

endmodule : flac_lock_store

// ===== logic/flac_pkg.sv
// Constants, encodings and helpers shared by the flash lock checker.
package flac_pkg;

    // ------------------------------------------------------------------
    // Widths and addresses
    // ------------------------------------------------------------------
    localparam int         PAGE_W        = 5;
    localparam int         LOCK_W        = 8;
    localparam logic [4:0] LOCK_PAGE_DEF = 5'h1E;

    // ------------------------------------------------------------------
    // Request encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] OP_READ       = 2'h0;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [1:0] OP_ERASE      = 2'h2;
    localparam logic [1:0] OP_FULL_ERASE = 2'h3;
    localparam logic       SRC_FIRMWARE  = 1'h0;
    localparam logic       SRC_DEBUG     = 1'h1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] LOCK_ERASED   = 8'hFF;

    // A page is locked when its lock bit is clear; the lock page follows
    // whenever any bit is clear, and pages past it are never lockable.
    function automatic logic page_locked(input logic [7:0] lock,
                                         input logic [4:0] page,
                                         input logic [4:0] lock_page);
        logic any;
        any = ~&lock;
        if (page == lock_page) begin
            page_locked = any;
        end else if (page < 5'(LOCK_W)) begin
            page_locked = ~lock[page[2:0]];
        end else begin
            page_locked = 1'b0;
        end
    endfunction : page_locked

endpackage : flac_pkg
